// [wakeup_pkg.sv]
// Purpose: Constants, register map and helpers of the wake-up timer and field detector.
// Assumes: Byte registers reached by the device's own register port, 100 MHz clock.
// Notes: Configuration and display registers all reset to zero.
// Contract
// [R1] Range bit picks 100 ms or 10 ms step
// [R2] Period is (code plus one) times step
// [R3] Periodic bit raises interrupt at every expiry
// [R4] Amplitude enable starts measurement at expiry
// [R5] Amplitude interrupt only when difference exceeds threshold
// [R6] Phase enable starts measurement at expiry
// [R7] Phase interrupt only when difference exceeds threshold
// [R8] Amplitude threshold sits in bits 7..4
// [R9] Phase threshold sits in bits 7..4
// [R10] Amplitude include bit folds triggering measurement in
// [R11] Phase include bit folds triggering measurement in
// [R12] Weight codes give 4, 8, 16, 32
// [R13] Amplitude averaging bit compares against running average
// [R14] Phase averaging bit compares against running average
// [R15] Amplitude reference register, read-write, resets zero
// [R16] Phase reference register, read-write, resets zero
// [R17] Amplitude running average readable
// [R18] Latest amplitude result readable
// [R19] Configuration cleared by reset and set-default
// [R20] Amplitude displays cleared by reset and set-default
// [R21] Phase running average readable, cleared likewise
// [R22] Latest phase result readable, cleared likewise
// [R23] Average moves by difference over weight, saturating
// [R24] Comparison uses absolute difference
package wakeup_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned STEP_SHORT_MS = 10;
  localparam int unsigned STEP_SHORT_CYCLES = STEP_SHORT_MS * 1000000 / CLK_PERIOD_NS;
  localparam logic [6:0] STEP_LONG_TICKS = 7'h0a; // 100 ms counted in 10 ms ticks.
  localparam logic [6:0] STEP_SHORT_TICKS = 7'h01;

  localparam logic [7:0] ADDR_TIMER_CTRL = 8'h31;
  localparam logic [7:0] ADDR_AMP_CFG = 8'h32;
  localparam logic [7:0] ADDR_AMP_REF = 8'h33;
  localparam logic [7:0] ADDR_AMP_AVG = 8'h34;
  localparam logic [7:0] ADDR_AMP_RESULT = 8'h35;
  localparam logic [7:0] ADDR_PHASE_CFG = 8'h36;
  localparam logic [7:0] ADDR_PHASE_REF = 8'h37;
  localparam logic [7:0] ADDR_PHASE_AVG = 8'h38;
  localparam logic [7:0] ADDR_PHASE_RESULT = 8'h39;

  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] TIMER_CTRL_MASK = 8'hfe;

  localparam int unsigned TIMER_RANGE_BIT = 7;
  localparam int unsigned TIMER_CODE_HI = 6;
  localparam int unsigned TIMER_CODE_LO = 4;
  localparam int unsigned TIMER_PERIODIC_BIT = 3;
  localparam int unsigned TIMER_AMP_BIT = 2;
  localparam int unsigned TIMER_PHASE_BIT = 1;

  localparam int unsigned CFG_LIMIT_HI = 7;
  localparam int unsigned CFG_LIMIT_LO = 4;
  localparam int unsigned CFG_INCLUDE_BIT = 3;
  localparam int unsigned CFG_WEIGHT_HI = 2;
  localparam int unsigned CFG_WEIGHT_LO = 1;
  localparam int unsigned CFG_AVG_REF_BIT = 0;

  localparam int unsigned CHANNELS = 2;
  localparam int unsigned CH_AMP = 0;
  localparam int unsigned CH_PHASE = 1;

  typedef enum logic [1:0] {
    CHECK_IDLE = 2'b00,
    CHECK_WAIT = 2'b01
  } check_state_t;

  function automatic logic [7:0] abs_diff(input logic [7:0] a, input logic [7:0] b);
    abs_diff = (a >= b) ? (a - b) : (b - a);
  endfunction : abs_diff
endpackage : wakeup_pkg

// [check_if.sv]
// Purpose: Carries one channel's settings, start and results between top and check unit.
// Assumes: One instance per measured quantity.
// Notes: The control side owns configuration, the unit owns results.
`timescale 1ns/1ps
interface check_if;
  logic [3:0] limit;
  logic include_trigger;
  logic [1:0] avg_weight;
  logic avg_as_ref;
  logic [7:0] ref_value;
  logic clear;
  logic start;
  logic meas_done;
  logic [7:0] meas_value;
  logic [7:0] avg_value;
  logic [7:0] result_value;
  logic irq;
  modport ctrl (
    output limit, include_trigger, avg_weight, avg_as_ref, ref_value, clear, start,
    output meas_done, meas_value,
    input avg_value, result_value, irq
  );
  modport unit (
    input limit, include_trigger, avg_weight, avg_as_ref, ref_value, clear, start,
    input meas_done, meas_value,
    output avg_value, result_value, irq
  );
endinterface : check_if

// [wakeup_tick_timer.sv]
// Purpose: Wake-up period counter producing a one-cycle expiry pulse.
// Assumes: Restart is pulsed whenever the period setting changes.
// Notes: A 10 ms prescaler feeds a tick counter so both ranges share one path.
`timescale 1ns/1ps
module wakeup_tick_timer #(
  parameter int unsigned STEP_CYCLES = wakeup_pkg::STEP_SHORT_CYCLES
) (
  input wire logic clk_in, // System clock.
  input wire logic rst_in, // Synchronous reset.
  input wire logic restart_in, // Restart the period from zero.
  input wire logic run_in, // Timer counts while high.
  input wire logic range_in, // 1 picks the short step.
  input wire logic [2:0] code_in, // Timeout code.
  output logic expire_out // One-cycle pulse at each expiry.
);
  logic [31:0] pre_q;
  logic [6:0] tick_q;
  logic [6:0] step_ticks;
  logic [6:0] target;
  logic tick;

  assign step_ticks = range_in ? wakeup_pkg::STEP_SHORT_TICKS : wakeup_pkg::STEP_LONG_TICKS; // R1
  assign target = 7'((8'(code_in) + 8'h01) * 8'(step_ticks)); // R2
  assign tick = (pre_q == 32'(STEP_CYCLES - 1));

  always_ff @(posedge clk_in) begin
    if (rst_in || restart_in || !run_in || tick) begin
      pre_q <= 32'h0;
    end else begin
      pre_q <= pre_q + 32'h1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in || restart_in || !run_in) begin
      tick_q <= 7'h0;
      expire_out <= 1'b0;
    end else if (tick && (tick_q == target - 7'h1)) begin
      tick_q <= 7'h0;
      expire_out <= 1'b1; // R2
    end else begin
      tick_q <= tick ? tick_q + 7'h1 : tick_q;
      expire_out <= 1'b0;
    end
  end
endmodule : wakeup_tick_timer

// [field_check.sv]
// Purpose: One measurement channel: compare with reference, flag change, keep average.
// Assumes: The front end answers each start with exactly one done pulse.
// Notes: Done pulses that arrive with no measurement pending are ignored.
`timescale 1ns/1ps
module field_check (
  input wire logic clk_in, // System clock.
  input wire logic rst_in, // Synchronous reset.
  check_if.unit ch // Channel settings and results.
);
  wakeup_pkg::check_state_t state_q;
  logic [7:0] avg_q;
  logic [7:0] result_q;
  logic irq_q;
  logic [7:0] ref_used;
  logic over;
  logic [9:0] diff;
  logic [9:0] step;
  logic [9:0] sum;

  assign ref_used = ch.avg_as_ref ? avg_q : ch.ref_value; // R13 R14
  assign over = wakeup_pkg::abs_diff(ch.meas_value, ref_used) > {4'h0, ch.limit}; // R24
  assign diff = {2'b00, ch.meas_value} - {2'b00, avg_q};
  assign step = $signed(diff) >>> (3'(ch.avg_weight) + 3'h2); // R12
  assign sum = {2'b00, avg_q} + step;

  always_ff @(posedge clk_in) begin
    if (rst_in || ch.clear) begin
      state_q <= wakeup_pkg::CHECK_IDLE;
    end else begin
      case (state_q)
        wakeup_pkg::CHECK_IDLE: state_q <= ch.start ? wakeup_pkg::CHECK_WAIT : state_q;
        wakeup_pkg::CHECK_WAIT: state_q <= ch.meas_done ? wakeup_pkg::CHECK_IDLE : state_q;
        default: state_q <= wakeup_pkg::CHECK_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in || ch.clear) begin
      result_q <= wakeup_pkg::REG_RESET; // R20 R22
      irq_q <= 1'b0;
    end else begin
      irq_q <= (state_q == wakeup_pkg::CHECK_WAIT) && ch.meas_done && over; // R5 R7
      if ((state_q == wakeup_pkg::CHECK_WAIT) && ch.meas_done) begin
        result_q <= ch.meas_value; // R18 R22
      end
    end
  end

  // Negative steps that overshoot below zero clamp at 0, positive ones at 255.
  always_ff @(posedge clk_in) begin
    if (rst_in || ch.clear) begin
      avg_q <= wakeup_pkg::REG_RESET; // R20 R21
    end else if ((state_q == wakeup_pkg::CHECK_WAIT) && ch.meas_done
                 && (!over || ch.include_trigger)) begin // R10 R11
      if (sum[9]) begin
        avg_q <= 8'h00; // R23
      end else if (sum[8]) begin
        avg_q <= 8'hff; // R23
      end else begin
        avg_q <= sum[7:0]; // R23
      end
    end
  end

  assign ch.avg_value = avg_q;
  assign ch.result_value = result_q;
  assign ch.irq = irq_q;
endmodule : field_check

// [wakeup_field_detect.sv]
// Purpose: Wake-up timer with amplitude and phase change detection and its registers.
// Assumes: Register strobes and measurement answers are synchronous one-cycle pulses.
// Notes: The timer runs only while at least one timeout action is enabled.
`timescale 1ns/1ps
module wakeup_field_detect #(
  parameter int unsigned STEP_CYCLES = wakeup_pkg::STEP_SHORT_CYCLES // Cycles per 10 ms.
) (
  input wire logic REF_CLK_IN, // 100 MHz clock.
  input wire logic SYS_RST_IN, // Synchronous reset, active high.
  input wire logic SET_DEFAULT_IN, // Set-default command pulse.
  input wire logic [7:0] REG_ADDR_IN, // Register address.
  input wire logic REG_WR_IN, // Write strobe.
  input wire logic [7:0] REG_WDATA_IN, // Write data.
  input wire logic REG_RD_IN, // Read strobe.
  output logic [7:0] REG_RDATA_OUT, // Read data, valid the cycle after the strobe.
  output logic AMP_START_OUT, // Start amplitude measurement pulse.
  input wire logic AMP_DONE_IN, // Amplitude measurement done pulse.
  input wire logic [7:0] AMP_RESULT_IN, // Amplitude result with done.
  output logic PHASE_START_OUT, // Start phase measurement pulse.
  input wire logic PHASE_DONE_IN, // Phase measurement done pulse.
  input wire logic [7:0] PHASE_RESULT_IN, // Phase result with done.
  output logic TIMER_IRQ_OUT, // Periodic timeout interrupt pulse.
  output logic AMP_IRQ_OUT, // Amplitude change interrupt pulse.
  output logic PHASE_IRQ_OUT // Phase change interrupt pulse.
);
  logic [7:0] timer_ctrl_q;
  logic [7:0] cfg_q [wakeup_pkg::CHANNELS];
  logic [7:0] ref_q [wakeup_pkg::CHANNELS];
  logic expire;
  logic timer_run;
  logic timer_restart;
  logic [wakeup_pkg::CHANNELS-1:0] start_q;
  logic [wakeup_pkg::CHANNELS-1:0] enable;
  logic [wakeup_pkg::CHANNELS-1:0] done;
  logic [7:0] meas [wakeup_pkg::CHANNELS];
  logic [7:0] avg_view [wakeup_pkg::CHANNELS];
  logic [7:0] result_view [wakeup_pkg::CHANNELS];
  logic [wakeup_pkg::CHANNELS-1:0] chk_irq;
  logic [wakeup_pkg::CHANNELS-1:0] chk_irq_q;
  logic timer_irq_q;
  logic [7:0] rdata_q;

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
    hit = (addr == target);
  endfunction : hit

  assign enable[wakeup_pkg::CH_AMP] = timer_ctrl_q[wakeup_pkg::TIMER_AMP_BIT];
  assign enable[wakeup_pkg::CH_PHASE] = timer_ctrl_q[wakeup_pkg::TIMER_PHASE_BIT];
  assign done[wakeup_pkg::CH_AMP] = AMP_DONE_IN;
  assign done[wakeup_pkg::CH_PHASE] = PHASE_DONE_IN;
  assign meas[wakeup_pkg::CH_AMP] = AMP_RESULT_IN;
  assign meas[wakeup_pkg::CH_PHASE] = PHASE_RESULT_IN;
  assign timer_run = |timer_ctrl_q[wakeup_pkg::TIMER_PERIODIC_BIT:wakeup_pkg::TIMER_PHASE_BIT];
  // A new period setting takes effect from a fresh start rather than mid-count.
  assign timer_restart = SET_DEFAULT_IN || (REG_WR_IN && hit(REG_ADDR_IN,
                         wakeup_pkg::ADDR_TIMER_CTRL));

  always_ff @(posedge REF_CLK_IN) begin
    if (SYS_RST_IN || SET_DEFAULT_IN) begin
      timer_ctrl_q <= wakeup_pkg::REG_RESET; // R19
    end else if (REG_WR_IN && hit(REG_ADDR_IN, wakeup_pkg::ADDR_TIMER_CTRL)) begin
      timer_ctrl_q <= REG_WDATA_IN & wakeup_pkg::TIMER_CTRL_MASK;
    end
  end

  wakeup_tick_timer #(
    .STEP_CYCLES(STEP_CYCLES)
  ) u_timer (
    .clk_in(REF_CLK_IN),
    .rst_in(SYS_RST_IN),
    .restart_in(timer_restart),
    .run_in(timer_run),
    .range_in(timer_ctrl_q[wakeup_pkg::TIMER_RANGE_BIT]), // R1
    .code_in(timer_ctrl_q[wakeup_pkg::TIMER_CODE_HI:wakeup_pkg::TIMER_CODE_LO]), // R2
    .expire_out(expire)
  );

  always_ff @(posedge REF_CLK_IN) begin
    if (SYS_RST_IN || SET_DEFAULT_IN) begin
      timer_irq_q <= 1'b0;
    end else begin
      timer_irq_q <= expire && timer_ctrl_q[wakeup_pkg::TIMER_PERIODIC_BIT]; // R3
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (SYS_RST_IN || SET_DEFAULT_IN) begin
      start_q <= '0;
    end else begin
      start_q <= {wakeup_pkg::CHANNELS{expire}} & enable; // R4 R6
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (SYS_RST_IN || SET_DEFAULT_IN) begin
      chk_irq_q <= '0;
    end else begin
      chk_irq_q <= chk_irq; // R5 R7
    end
  end

  // Both channels share one layout; only the register addresses differ.
  for (genvar c = 0; c < wakeup_pkg::CHANNELS; c++) begin : g_ch
    localparam logic [7:0] CFG_ADDR = (c == wakeup_pkg::CH_AMP) ?
        wakeup_pkg::ADDR_AMP_CFG : wakeup_pkg::ADDR_PHASE_CFG;
    localparam logic [7:0] REF_ADDR = (c == wakeup_pkg::CH_AMP) ?
        wakeup_pkg::ADDR_AMP_REF : wakeup_pkg::ADDR_PHASE_REF;
    check_if chi ();

    always_ff @(posedge REF_CLK_IN) begin
      if (SYS_RST_IN || SET_DEFAULT_IN) begin
        cfg_q[c] <= wakeup_pkg::REG_RESET; // R19
        ref_q[c] <= wakeup_pkg::REG_RESET; // R15 R16 R19
      end else if (REG_WR_IN) begin
        if (hit(REG_ADDR_IN, CFG_ADDR)) begin
          cfg_q[c] <= REG_WDATA_IN;
        end
        if (hit(REG_ADDR_IN, REF_ADDR)) begin
          ref_q[c] <= REG_WDATA_IN; // R15 R16
        end
      end
    end

    assign chi.limit = cfg_q[c][wakeup_pkg::CFG_LIMIT_HI:wakeup_pkg::CFG_LIMIT_LO]; // R8 R9
    assign chi.include_trigger = cfg_q[c][wakeup_pkg::CFG_INCLUDE_BIT]; // R10 R11
    assign chi.avg_weight = cfg_q[c][wakeup_pkg::CFG_WEIGHT_HI:wakeup_pkg::CFG_WEIGHT_LO]; // R12
    assign chi.avg_as_ref = cfg_q[c][wakeup_pkg::CFG_AVG_REF_BIT]; // R13 R14
    assign chi.ref_value = ref_q[c];
    assign chi.clear = SET_DEFAULT_IN; // R20
    assign chi.start = start_q[c];
    assign chi.meas_done = done[c];
    assign chi.meas_value = meas[c];
    assign avg_view[c] = chi.avg_value;
    assign result_view[c] = chi.result_value;
    assign chk_irq[c] = chi.irq;

    field_check u_check (
      .clk_in(REF_CLK_IN),
      .rst_in(SYS_RST_IN),
      .ch(chi.unit)
    );
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (SYS_RST_IN) begin
      rdata_q <= 8'h00;
    end else if (REG_RD_IN) begin
      case (REG_ADDR_IN)
        wakeup_pkg::ADDR_TIMER_CTRL: rdata_q <= timer_ctrl_q;
        wakeup_pkg::ADDR_AMP_CFG: rdata_q <= cfg_q[wakeup_pkg::CH_AMP];
        wakeup_pkg::ADDR_AMP_REF: rdata_q <= ref_q[wakeup_pkg::CH_AMP];
        wakeup_pkg::ADDR_AMP_AVG: rdata_q <= avg_view[wakeup_pkg::CH_AMP]; // R17
        wakeup_pkg::ADDR_AMP_RESULT: rdata_q <= result_view[wakeup_pkg::CH_AMP]; // R18
        wakeup_pkg::ADDR_PHASE_CFG: rdata_q <= cfg_q[wakeup_pkg::CH_PHASE];
        wakeup_pkg::ADDR_PHASE_REF: rdata_q <= ref_q[wakeup_pkg::CH_PHASE];
        wakeup_pkg::ADDR_PHASE_AVG: rdata_q <= avg_view[wakeup_pkg::CH_PHASE]; // R21
        wakeup_pkg::ADDR_PHASE_RESULT: rdata_q <= result_view[wakeup_pkg::CH_PHASE]; // R22
        default: rdata_q <= 8'h00;
      endcase
    end
  end

  assign REG_RDATA_OUT = rdata_q;
  assign AMP_START_OUT = start_q[wakeup_pkg::CH_AMP];
  assign PHASE_START_OUT = start_q[wakeup_pkg::CH_PHASE];
  assign TIMER_IRQ_OUT = timer_irq_q;
  assign AMP_IRQ_OUT = chk_irq_q[wakeup_pkg::CH_AMP];
  assign PHASE_IRQ_OUT = chk_irq_q[wakeup_pkg::CH_PHASE];
endmodule : wakeup_field_detect

// [wakeup_field_detect_asserts.sv]
// Purpose: Port-level assertions for the wake-up timer and field detector.
// Assumes: One clock domain; only the top module's ports are visible.
// Notes: The period check skips pulses that may still be in flight at a restart.
`timescale 1ns/1ps
module wakeup_field_detect_asserts #(
  parameter int unsigned STEP_CYCLES = 20
) (
  input wire logic REF_CLK_IN, // Clock.
  input wire logic SYS_RST_IN, // Reset.
  input wire logic SET_DEFAULT_IN, // Set-default pulse.
  input wire logic [7:0] REG_ADDR_IN, // Address.
  input wire logic REG_WR_IN, // Write strobe.
  input wire logic REG_RD_IN, // Read strobe.
  input wire logic [7:0] REG_RDATA_OUT, // Read data.
  input wire logic AMP_START_OUT, // Amplitude start.
  input wire logic AMP_DONE_IN, // Amplitude done.
  input wire logic PHASE_DONE_IN, // Phase done.
  input wire logic TIMER_IRQ_OUT, // Timeout interrupt.
  input wire logic AMP_IRQ_OUT, // Amplitude interrupt.
  input wire logic PHASE_IRQ_OUT // Phase interrupt.
);
  default clocking @(posedge REF_CLK_IN); endclocking
  default disable iff (SYS_RST_IN);
  logic restart;
  logic valid_q;
  logic [1:0] hold_q;
  int unsigned gap_q;
  assign restart = SET_DEFAULT_IN || (REG_WR_IN && REG_ADDR_IN == 8'h31);
  // A pulse launched before a restart would look like a short period, so it is not trusted.
  always_ff @(posedge REF_CLK_IN) begin
    if (SYS_RST_IN || restart) begin
      hold_q <= 2'h3;
      valid_q <= 1'b0;
      gap_q <= 0;
    end else begin
      if (hold_q != 2'h0) hold_q <= hold_q - 2'h1;
      if (TIMER_IRQ_OUT && hold_q == 2'h0) valid_q <= 1'b1;
      gap_q <= TIMER_IRQ_OUT ? 1 : gap_q + 1;
    end
  end
  a_timer_period_grid: assert property (TIMER_IRQ_OUT && valid_q |->
    gap_q % STEP_CYCLES == 0 && gap_q >= STEP_CYCLES && gap_q <= 80 * STEP_CYCLES)
    else $error("timeout period off the step grid");
  a_timer_irq_pulse: assert property (TIMER_IRQ_OUT |=> !TIMER_IRQ_OUT)
    else $error("timeout interrupt longer than one cycle");
  a_amp_start_pulse: assert property (AMP_START_OUT |=> !AMP_START_OUT)
    else $error("amplitude start longer than one cycle");
  a_amp_irq_cause: assert property ($rose(AMP_IRQ_OUT) |->
    $past(AMP_DONE_IN, 2) || $past(AMP_DONE_IN, 3))
    else $error("amplitude interrupt without a measurement");
  a_phase_irq_cause: assert property ($rose(PHASE_IRQ_OUT) |->
    $past(PHASE_DONE_IN, 2) || $past(PHASE_DONE_IN, 3))
    else $error("phase interrupt without a measurement");
  a_phase_irq_pulse: assert property (PHASE_IRQ_OUT |=> !PHASE_IRQ_OUT)
    else $error("phase interrupt longer than one cycle");
  a_default_clears_regs: assert property (SET_DEFAULT_IN ##1 !REG_WR_IN ##1
    (REG_RD_IN && !REG_WR_IN && !SET_DEFAULT_IN) |=> REG_RDATA_OUT == 8'h00)
    else $error("register not cleared by set-default");
  a_read_data_holds: assert property (!REG_RD_IN |=> $stable(REG_RDATA_OUT))
    else $error("read data changed without a read");
endmodule : wakeup_field_detect_asserts

bind wakeup_field_detect wakeup_field_detect_asserts #(.STEP_CYCLES(STEP_CYCLES)) u_asserts (
  .REF_CLK_IN, .SYS_RST_IN, .SET_DEFAULT_IN, .REG_ADDR_IN, .REG_WR_IN, .REG_RD_IN,
  .REG_RDATA_OUT, .AMP_START_OUT, .AMP_DONE_IN, .PHASE_DONE_IN, .TIMER_IRQ_OUT,
  .AMP_IRQ_OUT, .PHASE_IRQ_OUT
);

// [wakeup_field_detect_tb_top.sv]
// Purpose: Register-level test of the wake-up timer and field detector.
// Assumes: A short step parameter, so one 10 ms step lasts 20 cycles.
// Notes: The bench answers measurement starts in place of the analog front end.
`timescale 1ns/1ps
module wakeup_field_detect_tb_top;
  localparam int unsigned STEP = 20;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic sd = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic amp_done = 1'b0;
  logic ph_done = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] amp_res = 8'h00;
  logic [7:0] ph_res = 8'h00;
  logic [7:0] rdata;
  logic amp_start, ph_start, tmr_irq, amp_irq, ph_irq;
  int error_cnt = 0;
  int check_count = 0;
  int stray_cnt = 0;
  logic quiet = 1'b0;
  always #5 clk = ~clk;
  // Counts timeout interrupts or amplitude starts seen while their enable bits are clear.
  always @(posedge clk) begin
    if (quiet && (tmr_irq !== 1'b0 || amp_start !== 1'b0)) stray_cnt++;
  end
  wakeup_field_detect #(.STEP_CYCLES(STEP)) dut (
    .REF_CLK_IN(clk), .SYS_RST_IN(rst), .SET_DEFAULT_IN(sd), .REG_ADDR_IN(addr),
    .REG_WR_IN(wr), .REG_WDATA_IN(wdata), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata),
    .AMP_START_OUT(amp_start), .AMP_DONE_IN(amp_done), .AMP_RESULT_IN(amp_res),
    .PHASE_START_OUT(ph_start), .PHASE_DONE_IN(ph_done), .PHASE_RESULT_IN(ph_res),
    .TIMER_IRQ_OUT(tmr_irq), .AMP_IRQ_OUT(amp_irq), .PHASE_IRQ_OUT(ph_irq)
  );
  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk({8'h00, rdata}, {8'h00, e});
  endtask : rd_chk
  task automatic check_zero();
    for (int a = 8'h31; a <= 8'h3a; a++) rd_chk(8'(a), 8'h00);
  endtask : check_zero
  task automatic timer_gap(input logic [7:0] c);
    int n;
    n = 0;
    wr_reg(8'h31, c);
    // Skip a pulse that may already be on its way from the old setting.
    repeat (3) @(posedge clk);
    repeat (2000) begin
      @(posedge clk);
      if (tmr_irq === 1'b1) break;
    end
    do begin
      @(posedge clk);
      n++;
    end while (tmr_irq !== 1'b1 && n < 2000);
    chk(16'(n), 16'((c[6:4] + 1) * (c[7] ? 1 : 10) * STEP));
  endtask : timer_gap
  task automatic meas(input bit ch, input logic [7:0] v, input logic exp);
    logic seen;
    logic got_start;
    seen = 1'b0;
    got_start = 1'b0;
    repeat (300) begin
      @(posedge clk);
      got_start = ((ch ? ph_start : amp_start) === 1'b1);
      if (got_start) break;
    end
    chk(16'(got_start), 16'h0001);
    if (ch) ph_done <= 1'b1;
    else amp_done <= 1'b1;
    amp_res <= v;
    ph_res <= v;
    @(posedge clk);
    ph_done <= 1'b0;
    amp_done <= 1'b0;
    amp_res <= ~v;
    ph_res <= ~v;
    repeat (4) begin
      @(posedge clk);
      seen = seen | (ch ? ph_irq : amp_irq);
    end
    chk(16'(seen), 16'(exp));
  endtask : meas
  task automatic set_default();
    @(posedge clk);
    sd <= 1'b1;
    @(posedge clk);
    sd <= 1'b0;
  endtask : set_default
  initial begin
    logic [7:0] tc[3];
    int pa;
    tc = '{8'ha8, 8'h08, 8'hf8};
    pa = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    check_zero();
    wr_reg(8'h33, 8'ha5);
    rd_chk(8'h33, 8'ha5);
    wr_reg(8'h37, 8'h5a);
    rd_chk(8'h37, 8'h5a);
    wr_reg(8'h32, 8'hff);
    rd_chk(8'h32, 8'hff);
    wr_reg(8'h34, 8'hff);
    rd_chk(8'h34, 8'h00);
    wr_reg(8'h31, 8'h01);
    rd_chk(8'h31, 8'h00);
    foreach (tc[i]) timer_gap(tc[i]);
    wr_reg(8'h33, 8'h40);
    wr_reg(8'h32, 8'h48);
    wr_reg(8'h31, 8'h8c);
    meas(0, 8'h45, 1);
    rd_chk(8'h35, 8'h45);
    rd_chk(8'h34, 8'h11);
    meas(0, 8'h3c, 0);
    meas(0, 8'h30, 1);
    rd_chk(8'h34, 8'h20);
    wr_reg(8'h32, 8'h40);
    meas(0, 8'h90, 1);
    rd_chk(8'h34, 8'h20);
    wr_reg(8'h32, 8'h41);
    meas(0, 8'h22, 0);
    wr_reg(8'h32, 8'hfe);
    meas(0, 8'h60, 1);
    rd_chk(8'h34, 8'h22);
    meas(0, 8'h01, 1);
    rd_chk(8'h34, 8'h20);
    set_default();
    check_zero();
    wr_reg(8'h31, 8'h82);
    quiet <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      wr_reg(8'h36, {4'hf, 1'b1, 2'(k), 1'b0});
      meas(1, 8'h80, 1);
      pa = pa + ((8'h80 - pa) >> (k + 2));
      rd_chk(8'h38, 8'(pa));
    end
    rd_chk(8'h39, 8'h80);
    wr_reg(8'h36, 8'hf1);
    meas(1, 8'h38, 0);
    quiet <= 1'b0;
    set_default();
    check_zero();
    chk(16'(stray_cnt), 16'h0000);
    stop_test();
  end
  initial begin
    #200us;
    error_cnt++;
    stop_test();
  end
endmodule : wakeup_field_detect_tb_top
